/* File: core/tf_addr_if.sv */
// carries the current sector address and its successor between modules.
// assumes one stepper and one user on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tf_addr_if;
	logic        lba_mode;
	logic [3:0]  head;
	logic [15:0] cyl;
	logic [7:0]  sect;
	logic [3:0]  nxt_head;
	logic [15:0] nxt_cyl;
	logic [7:0]  nxt_sect;
	modport stepper (
		input  lba_mode,
		input  head,
		input  cyl,
		input  sect,
		output nxt_head,
		output nxt_cyl,
		output nxt_sect
	);
	modport user (
		output lba_mode,
		output head,
		output cyl,
		output sect,
		input  nxt_head,
		input  nxt_cyl,
		input  nxt_sect
	);
endinterface
`default_nettype wire

/* File: core/tf_addr_step.sv */
// successor of a sector address, in block or geometric form.
// assumes sector numbers start at one and geometry comes from the package.
`timescale 1ns/1ps
`default_nettype none
module tf_addr_step (
	tf_addr_if.stepper a
);
	logic [27:0] lba_next;

	assign lba_next = {a.head, a.cyl, a.sect} + 28'h0000001;

	always_comb begin
		if (a.lba_mode) begin
			{a.nxt_head, a.nxt_cyl, a.nxt_sect} = lba_next;
		end else if (a.sect != tf_pkg::GEO_SPT) begin
			a.nxt_head = a.head;
			a.nxt_cyl  = a.cyl;
			a.nxt_sect = a.sect + 8'h01;
		end else if (a.head != tf_pkg::GEO_HEADS) begin
			a.nxt_head = a.head + 4'h1;
			a.nxt_cyl  = a.cyl;
			a.nxt_sect = tf_pkg::SECT_BASE;
		end else begin
			a.nxt_head = 4'h0;
			a.nxt_cyl  = a.cyl + 16'h0001;
			a.nxt_sect = tf_pkg::SECT_BASE;
		end
	end
endmodule
`default_nettype wire

/* File: core/tf_pkg.sv */
// package for the task-file read engine: offsets, fields, opcodes.
// assumes a byte-wide register bus whose addresses are the printed offsets.
package tf_pkg;
	localparam logic [9:0] OFF_FEAT  = 10'h1f1;
	localparam logic [9:0] OFF_COUNT = 10'h1f2;
	localparam logic [9:0] OFF_SECT  = 10'h1f3;
	localparam logic [9:0] OFF_CYLLO = 10'h1f4;
	localparam logic [9:0] OFF_CYLHI = 10'h1f5;
	localparam logic [9:0] OFF_SEL   = 10'h1f6;
	localparam logic [9:0] OFF_OPC   = 10'h1f7;
	// drive/head select fields
	localparam int SEL_LBA   = 6;
	localparam int SEL_DRIVE = 4;
	// condition_flags bit positions
	localparam int FLAG_BSY  = 7;
	localparam int FLAG_DRDY = 6;
	localparam int FLAG_DSC  = 4;
	localparam int FLAG_DRQ  = 3;
	localparam int FLAG_ERR  = 0;
	// fault_report codes
	localparam logic [7:0] FAULT_UNC       = 8'h40;
	localparam logic [7:0] FAULT_ABRT      = 8'h04;
	localparam logic [7:0] FAULT_DIAG_PASS = 8'h01;
	localparam logic [7:0] FAULT_NONE      = 8'h00;
	// opcodes; bit 0 of the read opcode is don't-care
	localparam logic [7:0] OPC_READ  = 8'h20;
	localparam logic [7:0] OPC_DIAG  = 8'h90;
	localparam logic [8:0] FULL_RUN  = 9'h100;
	localparam logic [7:0] SECT_BASE = 8'h01;
	// disk geometry, plain defaults
	localparam logic [7:0] GEO_SPT   = 8'h3f;
	localparam logic [3:0] GEO_HEADS = 4'hf;
	typedef enum logic [1:0] {
		TF_IDLE,
		TF_SEEK,
		TF_FETCH,
		TF_DRQ
	} tf_state_t;
endpackage

/* File: core/tf_read_engine.sv */
// task-file registers and read-sectors command engine of the drive.
// assumes host bus and media engine run on core_clk; the drive strap is a pin.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - opcodes 0x20 and 0x21 both start read-sectors; bit 0 ignored
// - sector count gives sectors to read; zero means 256
// - with block addressing: head nibble, cylinders, sector form address
// - head off the requested track: seek first, then read the sector
// - data request is raised before each sector, even a failed one
// - success leaves last sector address in registers and count zero
// - a failing sector ends the command; no further sectors are read
// - after a failure registers hold failing address and untransferred count
// - registers not needed by a command are ignored by it
// - drive-only commands honour the drive bit and ignore the head field
// - broadcast commands run on both drives whichever is addressed
module tf_read_engine (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [9:0]  host_addr,
	input  wire logic        host_wr,
	input  wire logic        host_rd,
	input  wire logic [7:0]  host_wdata,
	output logic      [7:0]  host_rdata,
	input  wire logic        drive_strap,
	output logic             seek_req,
	output logic      [15:0] seek_cyl,
	input  wire logic        seek_done,
	output logic             read_req,
	output logic             read_lba_mode,
	output logic      [27:0] read_addr,
	input  wire logic        read_done,
	input  wire logic        read_err,
	output logic             data_req,
	input  wire logic        xfer_done
);
	tf_pkg::tf_state_t state;
	tf_pkg::tf_state_t next_state;
	logic [7:0]  feature_parameter;
	logic [7:0]  transfer_count;
	logic [7:0]  start_sector_index;
	logic [7:0]  cylinder_low_byte;
	logic [7:0]  cylinder_high_byte;
	logic [7:0]  drive_and_head_select;
	logic [7:0]  fault_report;
	logic        err_flag;
	logic        sec_err;
	logic [8:0]  remain;
	logic [15:0] track_pos;
	logic        strap_meta;
	logic        strap_sync;
	logic        busy;
	logic        may_write;
	logic        wr_opc;
	logic        selected;
	logic        start_read;
	logic        start_diag;
	logic        start_other;
	logic        sector_ok;
	logic        sector_bad;
	logic        last_ok;
	logic        step;
	logic        next_seek;
	logic [7:0]  flags;
	tf_addr_if   addr ();

	function automatic logic is_read(input logic [7:0] op);
		is_read = (op[7:1] == tf_pkg::OPC_READ[7:1]);
	endfunction

	assign addr.lba_mode = drive_and_head_select[tf_pkg::SEL_LBA];
	assign addr.head     = drive_and_head_select[3:0];
	assign addr.cyl      = {cylinder_high_byte, cylinder_low_byte};
	assign addr.sect     = start_sector_index;
	tf_addr_step u_step (
		.a (addr.stepper)
	);

	// strap is a pin: two flops before any use
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
		end else begin
			strap_meta <= drive_strap;
			strap_sync <= strap_meta;
		end
	end

	assign busy      = (state == tf_pkg::TF_SEEK)
		|| (state == tf_pkg::TF_FETCH);
	assign may_write = (state == tf_pkg::TF_IDLE);
	assign wr_opc    = host_wr && may_write && (host_addr == tf_pkg::OFF_OPC);
	assign selected  = (drive_and_head_select[tf_pkg::SEL_DRIVE] == strap_sync);
	assign start_read  = wr_opc && selected && is_read(host_wdata);
	assign start_diag  = wr_opc && (host_wdata == tf_pkg::OPC_DIAG);
	assign start_other = wr_opc && selected && !is_read(host_wdata)
		&& (host_wdata != tf_pkg::OPC_DIAG);
	assign sector_ok  = (state == tf_pkg::TF_DRQ) && xfer_done && !sec_err;
	assign sector_bad = (state == tf_pkg::TF_DRQ) && xfer_done && sec_err;
	assign last_ok    = sector_ok && (remain == 9'h001);
	assign step       = sector_ok && !last_ok;
	assign next_seek  = (addr.nxt_cyl != track_pos);

	always_comb begin
		next_state = state;
		case (state)
		tf_pkg::TF_IDLE: begin
			if (start_read && (addr.cyl != track_pos)) begin
				next_state = tf_pkg::TF_SEEK;
			end else if (start_read) begin
				next_state = tf_pkg::TF_FETCH;
			end
		end
		tf_pkg::TF_SEEK: begin
			if (seek_done) begin
				next_state = tf_pkg::TF_FETCH;
			end
		end
		tf_pkg::TF_FETCH: begin
			if (read_done) begin
				next_state = tf_pkg::TF_DRQ;
			end
		end
		default: begin
			if (sector_bad || last_ok) begin
				next_state = tf_pkg::TF_IDLE;
			end else if (step && next_seek) begin
				next_state = tf_pkg::TF_SEEK;
			end else if (step) begin
				next_state = tf_pkg::TF_FETCH;
			end
		end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= tf_pkg::TF_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// media strobes are one-cycle pulses on entry to a state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seek_req <= 1'b0;
			read_req <= 1'b0;
			data_req <= 1'b0;
			sec_err  <= 1'b0;
		end else begin
			seek_req <= (next_state == tf_pkg::TF_SEEK)
				&& (state != tf_pkg::TF_SEEK);
			read_req <= (next_state == tf_pkg::TF_FETCH)
				&& (state != tf_pkg::TF_FETCH);
			data_req <= (next_state == tf_pkg::TF_DRQ);
			if (state == tf_pkg::TF_FETCH && read_done) begin
				sec_err <= read_err;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			track_pos <= 16'h0000;
		end else if (state == tf_pkg::TF_SEEK && seek_done) begin
			track_pos <= addr.cyl;
		end
	end

	// task-file registers: host loads them only while idle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			feature_parameter     <= 8'h00;
			transfer_count        <= 8'h00;
			start_sector_index    <= tf_pkg::SECT_BASE;
			cylinder_low_byte     <= 8'h00;
			cylinder_high_byte    <= 8'h00;
			drive_and_head_select <= 8'h00;
		end else if (step) begin
			start_sector_index <= addr.nxt_sect;
			cylinder_low_byte  <= addr.nxt_cyl[7:0];
			cylinder_high_byte <= addr.nxt_cyl[15:8];
			drive_and_head_select[3:0] <= addr.nxt_head;
			transfer_count <= 8'(remain - 9'h001);
		end else if (last_ok) begin
			transfer_count <= 8'h00;
		end else if (host_wr && may_write) begin
			// feature value is kept but read never uses it
			if (host_addr == tf_pkg::OFF_FEAT) begin
				feature_parameter <= host_wdata;
			end else if (host_addr == tf_pkg::OFF_COUNT) begin
				transfer_count <= host_wdata;
			end else if (host_addr == tf_pkg::OFF_SECT) begin
				start_sector_index <= host_wdata;
			end else if (host_addr == tf_pkg::OFF_CYLLO) begin
				cylinder_low_byte <= host_wdata;
			end else if (host_addr == tf_pkg::OFF_CYLHI) begin
				cylinder_high_byte <= host_wdata;
			end else if (host_addr == tf_pkg::OFF_SEL) begin
				drive_and_head_select <= host_wdata;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			remain <= 9'h000;
		end else if (start_read) begin
			remain <= (transfer_count == 8'h00) ? tf_pkg::FULL_RUN
				: {1'b0, transfer_count};
		end else if (step) begin
			remain <= remain - 9'h001;
		end
	end

	// on failure address and count stay as they were for that sector
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_flag     <= 1'b0;
			fault_report <= tf_pkg::FAULT_NONE;
		end else if (sector_bad) begin
			err_flag     <= 1'b1;
			fault_report <= tf_pkg::FAULT_UNC;
		end else if (start_other) begin
			err_flag     <= 1'b1;
			fault_report <= tf_pkg::FAULT_ABRT;
		end else if (start_diag) begin
			err_flag     <= 1'b0;
			fault_report <= tf_pkg::FAULT_DIAG_PASS;
		end else if (start_read) begin
			err_flag     <= 1'b0;
			fault_report <= tf_pkg::FAULT_NONE;
		end
	end

	always_comb begin
		flags = 8'h00;
		flags[tf_pkg::FLAG_BSY]  = busy;
		flags[tf_pkg::FLAG_DRDY] = 1'b1;
		flags[tf_pkg::FLAG_DSC]  = (state != tf_pkg::TF_SEEK);
		flags[tf_pkg::FLAG_DRQ]  = data_req;
		flags[tf_pkg::FLAG_ERR]  = err_flag;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_rdata <= 8'h00;
		end else if (host_rd) begin
			if (host_addr == tf_pkg::OFF_FEAT) begin
				host_rdata <= fault_report;
			end else if (host_addr == tf_pkg::OFF_COUNT) begin
				host_rdata <= transfer_count;
			end else if (host_addr == tf_pkg::OFF_SECT) begin
				host_rdata <= start_sector_index;
			end else if (host_addr == tf_pkg::OFF_CYLLO) begin
				host_rdata <= cylinder_low_byte;
			end else if (host_addr == tf_pkg::OFF_CYLHI) begin
				host_rdata <= cylinder_high_byte;
			end else if (host_addr == tf_pkg::OFF_SEL) begin
				host_rdata <= drive_and_head_select;
			end else if (host_addr == tf_pkg::OFF_OPC) begin
				host_rdata <= flags;
			end else begin
				host_rdata <= 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seek_cyl      <= 16'h0000;
			read_lba_mode <= 1'b0;
			read_addr     <= 28'h0000000;
		end else begin
			seek_cyl      <= (state == tf_pkg::TF_DRQ) ? addr.nxt_cyl
				: addr.cyl;
			read_lba_mode <= addr.lba_mode;
			read_addr     <= (state == tf_pkg::TF_DRQ)
				? {addr.nxt_head, addr.nxt_cyl, addr.nxt_sect}
				: {addr.head, addr.cyl, addr.sect};
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_accept;
		start_read;
	endsequence
	sequence s_good_step;
		step;
	endsequence

	property p_opc_pair;
		wr_opc && selected && (host_wdata[7:1] == tf_pkg::OPC_READ[7:1])
			|=> (state != tf_pkg::TF_IDLE);
	endproperty
	a_opc_pair: assert property (p_opc_pair)
		else $error("read opcode not accepted");
	property p_full_run;
		s_accept ##0 (transfer_count == 8'h00) |=> (remain == 9'h100);
	endproperty
	a_full_run: assert property (p_full_run)
		else $error("zero count did not mean 256");
	property p_seek_first;
		s_accept ##0 (addr.cyl != track_pos) |=> seek_req && !read_req;
	endproperty
	a_seek_first: assert property (p_seek_first)
		else $error("read issued before seek");
	property p_drq_first;
		(state == tf_pkg::TF_FETCH) && read_done |=> data_req;
	endproperty
	a_drq_first: assert property (p_drq_first)
		else $error("no data request before sector");
	property p_done_zero;
		last_ok |=> (transfer_count == 8'h00) && !data_req
			##1 (state == tf_pkg::TF_IDLE);
	endproperty
	a_done_zero: assert property (p_done_zero)
		else $error("count not zero at completion");
	property p_err_stop;
		sector_bad |=> (err_flag && !read_req && !seek_req) [*2];
	endproperty
	a_err_stop: assert property (p_err_stop)
		else $error("read continued after failure");
	property p_err_regs;
		sector_bad |=> (transfer_count == $past(transfer_count))
			&& (start_sector_index == $past(start_sector_index));
	endproperty
	a_err_regs: assert property (p_err_regs)
		else $error("failure left wrong address or count");
	property p_step;
		s_good_step |=> (start_sector_index == $past(addr.nxt_sect))
			&& (remain == $past(remain) - 9'h001);
	endproperty
	a_step: assert property (p_step)
		else $error("address did not advance");
	property p_drive_only;
		wr_opc && !selected && (host_wdata != tf_pkg::OPC_DIAG)
			|=> (state == tf_pkg::TF_IDLE);
	endproperty
	a_drive_only: assert property (p_drive_only)
		else $error("other drive's command executed");
	property p_broadcast;
		start_diag |=> (fault_report == tf_pkg::FAULT_DIAG_PASS) && !err_flag;
	endproperty
	a_broadcast: assert property (p_broadcast)
		else $error("broadcast command not executed");
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the task-file read engine.
// assumes the media model stands behind the engine's seek/read ports.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        core_clk, rst_n, host_wr, host_rd, drive_strap, xfer_done;
	logic [9:0]  host_addr;
	logic [7:0]  host_wdata, host_rdata, s;
	logic        seek_req, seek_done, read_req, read_lba_mode;
	logic        read_done, read_err, data_req, slow, err_en;
	logic [15:0] seek_cyl, sk_cyl;
	logic [27:0] read_addr, err_addr;
	logic [28:0] addrs[$];
	int          err_count, samples_checked, n_sk;
	time         t_sk, t_rd;

	tf_read_engine dut (.core_clk(core_clk), .rst_n(rst_n),
		.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
		.host_wdata(host_wdata), .host_rdata(host_rdata),
		.drive_strap(drive_strap), .seek_req(seek_req),
		.seek_cyl(seek_cyl), .seek_done(seek_done), .read_req(read_req),
		.read_lba_mode(read_lba_mode), .read_addr(read_addr),
		.read_done(read_done), .read_err(read_err), .data_req(data_req),
		.xfer_done(xfer_done));
	tf_media_model media (.core_clk(core_clk), .rst_n(rst_n),
		.seek_req(seek_req), .seek_cyl(seek_cyl), .seek_done(seek_done),
		.read_req(read_req), .read_addr(read_addr), .read_done(read_done),
		.read_err(read_err), .slow(slow), .err_en(err_en),
		.err_addr(err_addr));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (read_req) begin
			addrs.push_back({read_lba_mode, read_addr});
			t_rd = $time;
		end
		if (seek_req) begin
			n_sk++;
			sk_cyl = seek_cyl;
			t_sk = $time;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge core_clk); #1;
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(posedge core_clk); #1;
		host_wr = 1'b0;
	endtask

	task automatic rd(input logic [9:0] a);
		@(posedge core_clk); #1;
		host_addr = a;
		host_rd = 1'b1;
		@(posedge core_clk); #1;
		host_rd = 1'b0;
		@(posedge core_clk); #1;
		s = host_rdata;
	endtask

	task automatic rchk(input logic [9:0] a, input logic [7:0] e);
		rd(a);
		chk(s, e);
	endtask

	// every parameter register except the feature is loaded before the opcode
	task automatic load(input logic [7:0] sel, cyh, cyl, sec, cnt);
		wr(tf_pkg::OFF_SEL, sel);
		wr(tf_pkg::OFF_CYLHI, cyh);
		wr(tf_pkg::OFF_CYLLO, cyl);
		wr(tf_pkg::OFF_SECT, sec);
		wr(tf_pkg::OFF_COUNT, cnt);
	endtask

	task automatic cmd(input logic [7:0] opc);
		rd(tf_pkg::OFF_OPC);
		chk({s[tf_pkg::FLAG_BSY], s[tf_pkg::FLAG_DRQ]}, 2'b00);
		addrs.delete();
		wr(tf_pkg::OFF_OPC, opc);
	endtask

	task automatic xfer(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			while (data_req !== 1'b1 && k < 100) begin
				@(posedge core_clk); #1;
				k++;
			end
			rd(tf_pkg::OFF_OPC);
			chk(s[tf_pkg::FLAG_DRQ], 1'b1);
			if (k >= 100)
				return;
			@(posedge core_clk); #1;
			xfer_done = 1'b1;
			@(posedge core_clk); #1;
			xfer_done = 1'b0;
			repeat (2) @(posedge core_clk);
			#1;
		end
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		s = 8'hff;
		while (s[tf_pkg::FLAG_BSY] !== 1'b0 && k < 50) begin
			rd(tf_pkg::OFF_OPC);
			k++;
		end
		chk({s[tf_pkg::FLAG_BSY], s[tf_pkg::FLAG_DRQ]}, 2'b00);
	endtask

	task automatic t_reset();
		rchk(tf_pkg::OFF_COUNT, 8'h00);
		rchk(tf_pkg::OFF_SECT, 8'h01);
		rchk(tf_pkg::OFF_CYLLO, 8'h00);
		rchk(tf_pkg::OFF_CYLHI, 8'h00);
		rchk(tf_pkg::OFF_SEL, 8'h00);
		rchk(tf_pkg::OFF_FEAT, 8'h00);
		rchk(10'h1f0, 8'h00);
		$display("test reset done");
	endtask

	// last sector of a track: next one is sector 1 of the next head
	task automatic t_chs();
		int sk0;
		sk0 = n_sk;
		wr(tf_pkg::OFF_FEAT, 8'ha5);
		load(8'h00, 8'h00, 8'h00, 8'h3f, 8'h02);
		cmd(tf_pkg::OPC_READ | 8'h01);
		xfer(2);
		wait_idle();
		chk(addrs.size(), 2);
		chk(addrs[0], 29'h000003f);
		chk(addrs[1], 29'h1000001);
		chk(n_sk - sk0, 0);
		rchk(tf_pkg::OFF_SECT, 8'h01);
		rchk(tf_pkg::OFF_SEL, 8'h01);
		rchk(tf_pkg::OFF_COUNT, 8'h00);
		$display("test chs done");
	endtask

	task automatic t_seek();
		slow = 1'b1;
		load(8'h00, 8'h00, 8'h05, 8'h01, 8'h01);
		cmd(tf_pkg::OPC_READ);
		xfer(1);
		wait_idle();
		chk(sk_cyl, 16'h0005);
		chk(t_sk < t_rd, 1);
		chk(addrs[0], 29'h0000501);
		slow = 1'b0;
		$display("test seek done");
	endtask

	task automatic t_err();
		err_en = 1'b1;
		err_addr = 28'ha123457;
		load(8'h4a, 8'h12, 8'h34, 8'h56, 8'h03);
		cmd(tf_pkg::OPC_READ);
		xfer(2);
		wait_idle();
		repeat (20) @(posedge core_clk);
		chk(addrs.size(), 2);
		chk(addrs[0], 29'h1a123456);
		rchk(tf_pkg::OFF_COUNT, 8'h02);
		rchk(tf_pkg::OFF_SECT, 8'h57);
		rchk(tf_pkg::OFF_CYLLO, 8'h34);
		rchk(tf_pkg::OFF_CYLHI, 8'h12);
		rchk(tf_pkg::OFF_SEL, 8'h4a);
		rchk(tf_pkg::OFF_FEAT, tf_pkg::FAULT_UNC);
		rd(tf_pkg::OFF_OPC);
		chk(s[tf_pkg::FLAG_ERR], 1'b1);
		err_en = 1'b0;
		$display("test error done");
	endtask

	task automatic t_full();
		load(8'h40, 8'h00, 8'h00, 8'h00, 8'h00);
		cmd(tf_pkg::OPC_READ);
		xfer(256);
		wait_idle();
		chk(addrs.size(), 256);
		chk(addrs[255], 29'h100000ff);
		rchk(tf_pkg::OFF_SECT, 8'hff);
		rchk(tf_pkg::OFF_COUNT, 8'h00);
		$display("test full count done");
	endtask

	task automatic t_select();
		wr(tf_pkg::OFF_SEL, 8'h10);
		cmd(tf_pkg::OPC_READ);
		repeat (20) @(posedge core_clk);
		chk(addrs.size(), 0);
		cmd(tf_pkg::OPC_DIAG);
		wait_idle();
		rchk(tf_pkg::OFF_FEAT, tf_pkg::FAULT_DIAG_PASS);
		wr(tf_pkg::OFF_SEL, 8'h0f);
		cmd(8'hef);
		wait_idle();
		rchk(tf_pkg::OFF_FEAT, tf_pkg::FAULT_ABRT);
		rd(tf_pkg::OFF_OPC);
		chk(s[tf_pkg::FLAG_ERR], 1'b1);
		// strap as drive 1: the drive bit set now selects this device
		drive_strap = 1'b1;
		load(8'h10, 8'h00, 8'h00, 8'h07, 8'h01);
		cmd(tf_pkg::OPC_READ);
		xfer(1);
		wait_idle();
		chk(addrs.size(), 1);
		chk(addrs[0], 29'h0000007);
		rd(tf_pkg::OFF_OPC);
		chk(s[tf_pkg::FLAG_ERR], 1'b0);
		drive_strap = 1'b0;
		$display("test select done");
	endtask

	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#1000000;
		err_count++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		results();
	end

	initial begin
		{rst_n, host_wr, host_rd, drive_strap, xfer_done} = 5'h00;
		{slow, err_en, err_addr} = 30'h0;
		host_addr = 10'h000;
		host_wdata = 8'h00;
		repeat (5) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_chs();
		t_seek();
		t_err();
		t_full();
		t_select();
		results();
	end
endmodule
`default_nettype wire

/* File: dv/tf_media_model.sv */
// behavioural media engine: answers seeks and sector fetches.
// assumes the engine's one-cycle request pulses, same clock as the bench.
`timescale 1ns/1ps
`default_nettype none
module tf_media_model (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        seek_req,
	input  wire logic [15:0] seek_cyl,
	output logic             seek_done,
	input  wire logic        read_req,
	input  wire logic [27:0] read_addr,
	output logic             read_done,
	output logic             read_err,
	input  wire logic        slow,
	input  wire logic        err_en,
	input  wire logic [27:0] err_addr
);
	logic [3:0]  sk_cnt;
	logic [3:0]  rd_cnt;
	logic [27:0] hold_addr;

	// read_err toggles outside read_done so a stale level never looks valid
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sk_cnt <= 4'h0;
			rd_cnt <= 4'h0;
			hold_addr <= 28'h0;
			seek_done <= 1'b0;
			read_done <= 1'b0;
			read_err <= 1'b0;
		end else begin
			seek_done <= 1'b0;
			read_done <= 1'b0;
			read_err <= ~read_err;
			if (seek_req) begin
				sk_cnt <= slow ? 4'h9 : 4'h2;
			end else if (sk_cnt != 4'h0) begin
				sk_cnt <= sk_cnt - 4'h1;
				seek_done <= (sk_cnt == 4'h1);
			end
			if (read_req) begin
				rd_cnt <= slow ? 4'h7 : 4'h2;
				hold_addr <= read_addr;
			end else if (rd_cnt != 4'h0) begin
				rd_cnt <= rd_cnt - 4'h1;
				if (rd_cnt == 4'h1) begin
					read_done <= 1'b1;
					read_err <= err_en && (hold_addr == err_addr);
				end
			end
		end
	end
endmodule
`default_nettype wire
